// [common/cache_sram_consts.svh]
// constants for the external cache write sequencer
// assumes inclusion by bare name from rtl files; no logic here
`ifndef CACHE_SRAM_CONSTS_SVH
`define CACHE_SRAM_CONSTS_SVH
`define WE_MASK_W 15
`define SPD_W 3
`define RANGE_W 4
`define CNT_W 4
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
`define WE_FIRST_BIT 4'h1
`endif

// [common/cache_sram_pkg.sv]
// types shared by the cache write sequencer files
// assumes no other package
package cache_sram_pkg;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_probe = 2'b01,
    st_write = 2'b10,
    st_read = 2'b11
  } seq_state_t;
endpackage

// [rtl/cycle_timer.sv]
// cycle timer: counts cycles of one cache access
// assumes the caller loads it on the first cycle of each access
`timescale 1ns/1ps
`include "cache_sram_consts.svh"
module cycle_timer #(
  parameter int CW = `CNT_W
) (
  // clocking
  input wire logic clk_sys,
  input wire logic rst_sync_b,
  input wire logic ce,
  // control
  input wire logic start,
  input wire logic [CW-1:0] last_idx,
  // status
  output logic [CW-1:0] idx,
  output logic done
);
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic busy_ff;
  logic nxt_busy;

  // done when the running index reaches the programmed last cycle
  assign idx = cnt_ff;
  assign done = busy_ff && (cnt_ff == last_idx);
  assign nxt_cnt = start ? `CNT_ZERO : (busy_ff && !done) ? cnt_ff + `CNT_ONE : cnt_ff;
  assign nxt_busy = start ? 1'b1 : (done ? 1'b0 : busy_ff);

  // counter state
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cnt_ff <= `CNT_ZERO;
      busy_ff <= 1'b0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
    end
  end
endmodule

// [rtl/cache_sram_write_timing.sv]
// cache access sequencer for an external asynchronous sram cache
// assumes requests and config ports synchronous to clk_sys; board buffers outside
`timescale 1ns/1ps
`include "cache_sram_consts.svh"
module cache_sram_write_timing #(
  parameter int ADR_W = 29,
  parameter int DAT_W = 128,
  parameter int TAG_W = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  // bus interface control register fields
  input wire logic [`WE_MASK_W-1:0] cache_write_pulse_mask,
  input wire logic [`SPD_W-1:0] cache_write_cycle_length,
  input wire logic [`SPD_W-1:0] cache_read_cycle_length,
  input wire logic [`RANGE_W-1:0] cache_range_disable,
  // processor request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADR_W-1:0] req_adr,
  input wire logic [1:0] req_range,
  input wire logic [DAT_W-1:0] req_data,
  input wire logic [TAG_W-1:0] req_tag_ctl,
  output logic req_ready,
  output logic req_bypass,
  // completion
  output logic done_pulse,
  output logic [DAT_W-1:0] rd_data,
  // sram side
  output logic [ADR_W-1:0] cache_adr,
  output logic [DAT_W-1:0] cache_wdata,
  output logic cache_data_oe_b,
  output logic [TAG_W-1:0] tag_ctl,
  output logic tag_ctl_oe_b,
  output logic cache_we,
  output logic cache_oe,
  input wire logic [DAT_W-1:0] cache_rdata
);
  // ******************************
  // reset release
  // ******************************
  logic rst_s1_ff;
  logic rst_sync_b;
  logic rst_s2_ff;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  assign rst_sync_b = rst_s2_ff;

  // ******************************
  // sequencing
  // ******************************
  cache_sram_pkg::seq_state_t state_ff;
  cache_sram_pkg::seq_state_t nxt_state;
  logic [ADR_W-1:0] adr_ff;
  logic [DAT_W-1:0] wdata_ff;
  logic [TAG_W-1:0] tag_hold_ff;
  logic [TAG_W-1:0] tag_ff;
  logic tag_oe_b_ff;
  logic data_oe_b_ff;
  logic we_ff;
  logic oe_ff;
  logic done_ff;
  logic [DAT_W-1:0] rdata_ff;
  logic start_t;
  logic [`CNT_W-1:0] last_idx;
  logic [`CNT_W-1:0] idx;
  logic t_done;
  logic bypass;
  logic take;
  logic start_write;
  logic [`CNT_W-1:0] we_idx;
  logic nxt_we;

  // ******************************
  // request intake
  // ******************************
  // a request is taken only while idle; disabled ranges never touch the sram
  // a bypassed request is answered in the same cycle and leaves the timer untouched
  assign bypass = cache_range_disable[req_range];
  assign req_ready = (state_ff == cache_sram_pkg::st_idle);
  assign req_bypass = req_ready && req_valid && bypass;
  assign take = req_ready && req_valid && !bypass;
  assign start_write = (state_ff == cache_sram_pkg::st_probe) && t_done;
  assign start_t = take || start_write;
  // probe and read use read length; write uses write length
  // chosen from the present state only: start_write depends on the timer's done,
  // so feeding it back here would close a combinational loop through the timer
  assign last_idx = (state_ff == cache_sram_pkg::st_write) ?
                    {1'b0, cache_write_cycle_length} :
                    {1'b0, cache_read_cycle_length};

  // ******************************
  // next state
  // ******************************
  // next state: a write is always a probe followed by the write itself
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      cache_sram_pkg::st_idle: begin
        if (take) begin
          nxt_state = req_write ? cache_sram_pkg::st_probe : cache_sram_pkg::st_read;
        end
      end
      cache_sram_pkg::st_probe: begin
        if (t_done) begin
          nxt_state = cache_sram_pkg::st_write;
        end
      end
      cache_sram_pkg::st_write: begin
        if (t_done) begin
          nxt_state = cache_sram_pkg::st_idle;
        end
      end
      cache_sram_pkg::st_read: begin
        if (t_done) begin
          nxt_state = cache_sram_pkg::st_idle;
        end
      end
      default: nxt_state = cache_sram_pkg::st_idle;
    endcase
  end

  // ******************************
  // cycle timer
  // ******************************
  // one shared timer serves probe, read and write; a start reloads it to cycle 0,
  // so the length it compares against only matters from the following cycle on
  cycle_timer #(.CW(`CNT_W)) u_timer (
    .clk_sys(clk_sys),
    .rst_sync_b(rst_sync_b),
    .ce(ce),
    .start(start_t),
    .last_idx(last_idx),
    .idx(idx),
    .done(t_done)
  );

  // ******************************
  // write pulse placement
  // ******************************
  // mask bits past the programmed write length are simply never reached
  // write enable for the coming cycle: cycle k (k>=1) uses mask bit k-1
  // the counter points at cycle idx now, so next cycle is idx+1
  assign we_idx = start_write ? `CNT_ZERO : idx;
  assign nxt_we = ((state_ff == cache_sram_pkg::st_write) && !t_done) &&
                  (we_idx < `WE_MASK_W) && cache_write_pulse_mask[we_idx];

  // ******************************
  // address and data hold
  // ******************************
  // address and data latched once per request and held through the write
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      adr_ff <= '0;
      wdata_ff <= '0;
      tag_hold_ff <= '0;
    end else if (ce && take) begin
      adr_ff <= req_adr;
      wdata_ff <= req_data;
      tag_hold_ff <= req_tag_ctl;
    end
  end

  // ******************************
  // strobes and completion
  // ******************************
  // tag enable trails data enable also at the end, so tag hold time is never shorter
  // drive strobes; tag control follows data enable by one cycle
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_ff <= cache_sram_pkg::st_idle;
      data_oe_b_ff <= 1'b1;
      tag_oe_b_ff <= 1'b1;
      tag_ff <= '0;
      we_ff <= 1'b0;
      oe_ff <= 1'b0;
      done_ff <= 1'b0;
      rdata_ff <= '0;
    end else if (ce) begin
      state_ff <= nxt_state;
      data_oe_b_ff <= !(start_write || ((state_ff == cache_sram_pkg::st_write) && !t_done));
      tag_oe_b_ff <= data_oe_b_ff;
      tag_ff <= data_oe_b_ff ? '0 : tag_hold_ff;
      we_ff <= nxt_we;
      oe_ff <= take || ((state_ff == cache_sram_pkg::st_probe || state_ff == cache_sram_pkg::st_read) && !t_done);
      done_ff <= t_done && (state_ff == cache_sram_pkg::st_write || state_ff == cache_sram_pkg::st_read);
      if (t_done && state_ff == cache_sram_pkg::st_read) begin
        rdata_ff <= cache_rdata;
      end
    end
  end

  // ******************************
  // output drive
  // ******************************
  // registered outputs keep decode glitches off the board buffers and the gate
  // outputs straight from flops
  assign cache_adr = adr_ff;
  assign cache_wdata = wdata_ff;
  assign cache_data_oe_b = data_oe_b_ff;
  assign tag_ctl = tag_ff;
  assign tag_ctl_oe_b = tag_oe_b_ff;
  assign cache_we = we_ff;
  assign cache_oe = oe_ff;
  assign done_pulse = done_ff;
  assign rd_data = rdata_ff;
endmodule

// [verification/cache_sram_write_timing_sva.sv]
// checker for the cache write sequencer port timing
// assumes ce held high and one clk_sys domain
`timescale 1ns/1ps
module cache_sram_write_timing_sva (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // config and request
  input wire logic [14:0] cache_write_pulse_mask,
  input wire logic [2:0] cache_write_cycle_length,
  input wire logic [2:0] cache_read_cycle_length,
  input wire logic [3:0] cache_range_disable,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [1:0] req_range,
  input wire logic req_bypass,
  // sram side
  input wire logic [28:0] cache_adr,
  input wire logic [127:0] cache_wdata,
  input wire logic cache_data_oe_b,
  input wire logic tag_ctl_oe_b,
  input wire logic cache_we,
  input wire logic cache_oe
);
  logic [3:0] wc_ff, pc_ff, nxt_wc, nxt_pc;
  // cycle index within write and probe phases
  assign nxt_wc = cache_data_oe_b ? 4'h0 : wc_ff + 4'h1;
  assign nxt_pc = cache_oe ? pc_ff + 4'h1 : 4'h0;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wc_ff <= 4'h0;
      pc_ff <= 4'h0;
    end else begin
      wc_ff <= nxt_wc;
      pc_ff <= nxt_pc;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  chk_we_first: assert property ($fell(cache_data_oe_b) |-> !cache_we) else $error("we in cycle 0");
  chk_we_mask: assert property (!cache_data_oe_b |-> cache_we ==
    (wc_ff != 4'h0 && cache_write_pulse_mask[wc_ff - 4'h1])) else $error("we off mask");
  chk_we_outside: assert property (cache_we |-> !cache_data_oe_b) else $error("we outside write");
  chk_write_len: assert property ($rose(cache_data_oe_b) |->
    wc_ff == {1'b0, cache_write_cycle_length} + 4'h1) else $error("write length");
  chk_tag_lag: assert property (tag_ctl_oe_b == $past(cache_data_oe_b)) else $error("tag lag");
  chk_probe_first: assert property ($fell(cache_data_oe_b) |-> $past(cache_oe)) else $error("no probe");
  chk_probe_len: assert property ($fell(cache_oe) |->
    pc_ff == {1'b0, cache_read_cycle_length} + 4'h1) else $error("probe length");
  chk_range_skip: assert property (req_valid && req_ready |->
    req_bypass == cache_range_disable[req_range]) else $error("bypass");
  chk_adr_hold: assert property (!cache_data_oe_b |->
    $stable(cache_adr) && $stable(cache_wdata)) else $error("adr moved");
endmodule
bind cache_sram_write_timing cache_sram_write_timing_sva CHK (.clk_sys, .rst_b, .cache_write_pulse_mask,
  .cache_write_cycle_length, .cache_read_cycle_length, .cache_range_disable, .req_valid, .req_ready,
  .req_range, .req_bypass, .cache_adr, .cache_wdata, .cache_data_oe_b, .tag_ctl_oe_b, .cache_we, .cache_oe);

// [verification/sram_cache_model.sv]
// asynchronous sram data array on the far side
// assumes only low address bits decoded; no pull on the data lines
`timescale 1ns/1ps
module sram_cache_model (
  // sram pins
  input wire logic clk_sys,
  input wire logic cache_we,
  input wire logic cache_oe,
  input wire logic [28:0] cache_adr,
  input wire logic [127:0] cache_wdata,
  output logic [127:0] cache_rdata
);
  logic [127:0] mem [16];
  logic [127:0] last_ff = '0;
  // released bus shows inverse of last value so stale data never passes
  assign cache_rdata = cache_oe ? mem[cache_adr[3:0]] : ~last_ff;
  always_ff @(posedge clk_sys) begin
    if (cache_we) mem[cache_adr[3:0]] <= cache_wdata;
    if (cache_oe) last_ff <= mem[cache_adr[3:0]];
  end
endmodule

// [verification/cache_sram_write_timing_bench.sv]
// bench: random write then read pairs against a reference memory
// assumes the sram model on the far side and ce held high
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected %0t value mismatch", $time); end end
module cache_sram_write_timing_bench;
  logic clk_sys = 1'b0, rst_b = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic [14:0] mask = '0;
  logic [2:0] wlen = '0, rlen = '0;
  logic [3:0] dis = 4'h4, req_tag_ctl = '0, tag_ctl, pa;
  logic [28:0] req_adr = '0, cache_adr;
  logic [1:0] req_range = '0, pr;
  logic [127:0] req_data = '0, cache_rdata, rd_data, cache_wdata, em [16];
  logic req_ready, req_bypass, done_pulse, cache_data_oe_b, tag_ctl_oe_b, cache_we, cache_oe;
  logic [31:0] rnd = 32'h00011FEA;
  int fail_count = 0, total_checks = 0;
  always #2 clk_sys = ~clk_sys;
  cache_sram_write_timing DUT (.clk_sys, .rst_b, .ce(1'b1), .cache_write_pulse_mask(mask),
    .cache_write_cycle_length(wlen), .cache_read_cycle_length(rlen), .cache_range_disable(dis),
    .req_valid, .req_write, .req_adr, .req_range, .req_data, .req_tag_ctl, .req_ready, .req_bypass,
    .done_pulse, .rd_data, .cache_adr, .cache_wdata, .cache_data_oe_b, .tag_ctl, .tag_ctl_oe_b,
    .cache_we, .cache_oe, .cache_rdata);
  sram_cache_model SRAM (.clk_sys, .cache_we, .cache_oe, .cache_adr, .cache_wdata, .cache_rdata);
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one access with fresh random timing fields; latency counted in negedges
  task automatic op(input logic wr, input logic [3:0] a, input logic [1:0] rg);
    int n = 0;
    @(negedge clk_sys);
    while (req_ready !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    rnd = lfsr(rnd);
    mask = rnd[14:0];
    wlen = rnd[17:15];
    rlen = rnd[20:18];
    req_tag_ctl = rnd[24:21];
    req_write = wr;
    req_adr = {25'h0000000, a};
    req_range = rg;
    req_data = {4{rnd}};
    req_valid = 1'b1;
    #1 `CHK(req_bypass, dis[rg])
    @(negedge clk_sys) req_valid = 1'b0;
    n = 0;
    if (!dis[rg]) begin
      while (done_pulse !== 1'b1 && n < 40) begin
        @(negedge clk_sys);
        n++;
      end
      `CHK(n, wr ? 2 + rlen + wlen : 1 + rlen)
      if (wr) begin
        `CHK({tag_ctl_oe_b, tag_ctl}, {1'b0, req_tag_ctl})
        // the write only lands if some mask bit falls in write cycles 1..W
        if ((mask & ((15'h0001 << wlen) - 15'h0001)) != 15'h0000) em[a] = req_data;
      end else `CHK(rd_data, em[a])
    end
  endtask
  // watchdog far beyond 48 accesses of at most 20 cycles
  initial begin
    #20000;
    fail_count++;
    results();
  end
  initial begin
    repeat (8) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (3) @(negedge clk_sys);
    for (int i = 0; i < 24; i++) begin
      rnd = lfsr(rnd);
      pa = rnd[3:0];
      pr = rnd[26:25];
      op(1'b1, pa, pr);
      op(1'b0, pa, pr);
    end
    results();
  end
endmodule
